//--- hw/dct_consts.svh
// Operation
// - phase trim: bit5 clear loads positive input, set loads negative; zero codes none.
// - receiver power-down bit holds clock off while set; resets set.
// - duty trim: bit 4 is skew direction, low four bits magnitude 0..15.
// - larger duty magnitude gives proportionally larger skew; full scale spans 3 percent.
// - boost bit widens duty span to 5 percent; clear keeps normal span.
// - reference rate field: 00 single rate, 01 double rate; resets 00.
`ifndef DCT_CONSTS_SVH
`define DCT_CONSTS_SVH
`define DCT_ADDR_W        15
`define DCT_ADDR_PHASE    15'h007f
`define DCT_ADDR_PD       15'h0080
`define DCT_ADDR_DUTY     15'h0082
`define DCT_ADDR_CRS      15'h0083
`define DCT_ADDR_PLLREF   15'h0084
`define DCT_RST_PHASE     6'h00
`define DCT_RST_PD        1'h1
`define DCT_RST_DUTY      8'h80
`define DCT_RST_CRS_EN    1'h1
`define DCT_RST_CRS_ADJ   4'h0
`define DCT_RST_RATE      2'h0
`define DCT_PHASE_SIGN    5
`define DCT_DUTY_EN       7
`define DCT_DUTY_OFS      6
`define DCT_DUTY_BOOST    5
`define DCT_DUTY_SIGN     4
`define DCT_CRS_EN        7
`define DCT_RATE_LO       4
`define DCT_SPAN_NORMAL   3'h3
`define DCT_SPAN_BOOST    3'h5
`define DCT_INSTR_BITS    5'h10
`define DCT_LAST_BIT      5'h17
`define DCT_RD_FLAG       15
`endif

//--- hw/dct_pkg.sv
package dct_pkg;
	typedef struct packed {
		logic       powerdown;
		logic [4:0] pos_cap;
		logic [4:0] neg_cap;
		logic       duty_enable;
		logic       duty_offset_en;
		logic       duty_range_boost;
		logic       duty_dir;
		logic [3:0] duty_mag;
		logic [2:0] duty_span_pct;
		logic       crossing_adjust_enable;
		logic [3:0] crossing_point_trim;
		logic [1:0] ref_rate;
	} dct_ctrl_t;
endpackage

//--- hw/dct_clock_regs.sv
`timescale 1ns/1ps
`include "dct_consts.svh"
module dct_clock_regs (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// configuration serial port
	input  wire logic             spi_cs_n,
	input  wire logic             spi_sclk,
	input  wire logic             spi_sdi,
	output logic                  spi_sdo,
	output logic                  spi_sdo_oe,
	// clock path controls
	output dct_pkg::dct_ctrl_t    ctrl
);
	logic [2:0]  cs_sync;
	logic [2:0]  sclk_sync;
	logic [2:0]  sdi_sync;
	logic        cs_f;
	logic        sclk_f;
	logic        sdi_f;
	logic        sclk_q;
	logic [4:0]  bit_cnt;
	logic [15:0] shift_in;
	logic [7:0]  rd_shift;
	logic        rd_mode;
	logic [5:0]  phase_reg;
	logic        pd_reg;
	logic [7:0]  duty_reg;
	logic        crs_en_reg;
	logic [3:0]  crs_adj_reg;
	logic [1:0]  rate_reg;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        wr_commit;
	logic [7:0]  wr_data;
	logic [14:0] addr;

	// reset image of the duty register, so ctrl starts from the same enable bit
	localparam logic [7:0] duty_rst_val = `DCT_RST_DUTY;

	// readback with reserved bits forced low
	function automatic logic [7:0] read_map(input logic [14:0] a);
		unique case (a)
			`DCT_ADDR_PHASE:  read_map = {2'h0, phase_reg};
			`DCT_ADDR_PD:     read_map = {7'h00, pd_reg};
			`DCT_ADDR_DUTY:   read_map = duty_reg;
			`DCT_ADDR_CRS:    read_map = {crs_en_reg, 3'h0, crs_adj_reg};
			`DCT_ADDR_PLLREF: read_map = {2'h0, rate_reg, 4'h0};
			default:          read_map = 8'h00;
		endcase
	endfunction

	// three stages; a level counts once stages two and three agree
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cs_sync   <= 3'h7;
			sclk_sync <= 3'h0;
			sdi_sync  <= 3'h0;
			cs_f      <= 1'h1;
			sclk_f    <= 1'h0;
			sdi_f     <= 1'h0;
			sclk_q    <= 1'h0;
		end else begin
			cs_sync   <= {cs_sync[1:0], spi_cs_n};
			sclk_sync <= {sclk_sync[1:0], spi_sclk};
			sdi_sync  <= {sdi_sync[1:0], spi_sdi};
			if (cs_sync[1] == cs_sync[2])
				cs_f <= cs_sync[2];
			if (sclk_sync[1] == sclk_sync[2])
				sclk_f <= sclk_sync[2];
			if (sdi_sync[1] == sdi_sync[2])
				sdi_f <= sdi_sync[2];
			sclk_q    <= sclk_f;
		end
	end

	assign sclk_rise = !cs_f && sclk_f && !sclk_q;
	assign sclk_fall = !cs_f && !sclk_f && sclk_q;
	assign wr_data   = {shift_in[6:0], sdi_f};
	assign wr_commit = sclk_rise && !rd_mode && bit_cnt == `DCT_LAST_BIT;

	// 16-bit instruction (read flag, address) then one data byte, msb first
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bit_cnt  <= 5'h00;
			shift_in <= 16'h0000;
			addr     <= 15'h0000;
			rd_mode  <= 1'h0;
		end else if (cs_f) begin
			bit_cnt  <= 5'h00;
			rd_mode  <= 1'h0;
		end else if (sclk_rise) begin
			shift_in <= {shift_in[14:0], sdi_f};
			// address held here; shift_in is too short to keep it past the data byte
			if (bit_cnt == `DCT_INSTR_BITS - 5'h01) begin
				rd_mode <= shift_in[`DCT_RD_FLAG - 1];
				addr    <= {shift_in[13:0], sdi_f};
			end
			// one byte per frame; extra clocks are ignored
			if (bit_cnt != `DCT_LAST_BIT + 5'h01)
				bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// read byte loaded once the address is whole, shifted on falling edges
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_shift <= 8'h00;
		end else if (sclk_rise && bit_cnt == `DCT_INSTR_BITS - 5'h01) begin
			rd_shift <= read_map({shift_in[13:0], sdi_f});
		end else if (sclk_fall && rd_mode && bit_cnt > `DCT_INSTR_BITS) begin
			rd_shift <= {rd_shift[6:0], 1'h0};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			spi_sdo    <= 1'h0;
			spi_sdo_oe <= 1'h0;
		end else begin
			spi_sdo    <= rd_shift[7];
			spi_sdo_oe <= !cs_f && rd_mode && bit_cnt >= `DCT_INSTR_BITS;
		end
	end

	// register writes; only documented field bits are stored
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_reg   <= `DCT_RST_PHASE;
			pd_reg      <= `DCT_RST_PD;
			duty_reg    <= `DCT_RST_DUTY;
			crs_en_reg  <= `DCT_RST_CRS_EN;
			crs_adj_reg <= `DCT_RST_CRS_ADJ;
			rate_reg    <= `DCT_RST_RATE;
		end else if (wr_commit) begin
			unique case (addr)
				`DCT_ADDR_PHASE:  phase_reg <= wr_data[5:0];
				`DCT_ADDR_PD:     pd_reg <= wr_data[0];
				`DCT_ADDR_DUTY:   duty_reg <= wr_data;
				`DCT_ADDR_CRS: begin
					crs_en_reg  <= wr_data[`DCT_CRS_EN];
					crs_adj_reg <= wr_data[3:0];
				end
				`DCT_ADDR_PLLREF: rate_reg <= wr_data[`DCT_RATE_LO +: 2];
				default: ;
			endcase
		end
	end

	// decoded controls, registered so the analog side sees clean levels
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl <= '0;
			ctrl.powerdown <= `DCT_RST_PD;
			ctrl.duty_enable <= duty_rst_val[`DCT_DUTY_EN];
			ctrl.duty_span_pct <= `DCT_SPAN_NORMAL;
			ctrl.crossing_adjust_enable <= `DCT_RST_CRS_EN;
		end else begin
			ctrl.powerdown              <= pd_reg;
			ctrl.pos_cap                <= phase_reg[`DCT_PHASE_SIGN] ? 5'h00 : phase_reg[4:0];
			ctrl.neg_cap                <= phase_reg[`DCT_PHASE_SIGN] ? phase_reg[4:0] : 5'h00;
			ctrl.duty_enable            <= duty_reg[`DCT_DUTY_EN];
			ctrl.duty_offset_en         <= duty_reg[`DCT_DUTY_OFS];
			ctrl.duty_range_boost       <= duty_reg[`DCT_DUTY_BOOST];
			ctrl.duty_dir               <= duty_reg[`DCT_DUTY_SIGN];
			ctrl.duty_mag               <= duty_reg[3:0];
			// span that full-scale magnitude reaches; boost costs phase noise
			ctrl.duty_span_pct          <= duty_reg[`DCT_DUTY_BOOST] ? `DCT_SPAN_BOOST : `DCT_SPAN_NORMAL;
			ctrl.crossing_adjust_enable <= crs_en_reg;
			ctrl.crossing_point_trim    <= crs_adj_reg;
			ctrl.ref_rate               <= rate_reg;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_pd_write;
		wr_commit && addr == `DCT_ADDR_PD;
	endsequence

	property p_phase_pos;
		##1 ctrl.pos_cap == ($past(phase_reg[5]) ? 5'h00 : $past(phase_reg[4:0]));
	endproperty
	a_phase_pos: assert property (p_phase_pos) else $error("positive cap trim wrong");

	property p_phase_neg;
		##1 (ctrl.neg_cap == 5'h00) == (!$past(phase_reg[5]) || $past(phase_reg[4:0]) == 5'h00);
	endproperty
	a_phase_neg: assert property (p_phase_neg) else $error("negative cap trim wrong");

	property p_pd_write;
		s_pd_write |=> (pd_reg == $past(sdi_f)) ##1 (ctrl.powerdown == pd_reg);
	endproperty
	a_pd_write: assert property (p_pd_write) else $error("power-down write not applied");

	property p_duty_split;
		##1 {ctrl.duty_dir, ctrl.duty_mag} == $past(duty_reg[4:0]);
	endproperty
	a_duty_split: assert property (p_duty_split) else $error("duty trim split wrong");

	property p_duty_full;
		(duty_reg[3:0] == 4'hf && !duty_reg[5]) |=> (ctrl.duty_mag == 4'hf && ctrl.duty_span_pct == 3'h3);
	endproperty
	a_duty_full: assert property (p_duty_full) else $error("full scale duty span wrong");

	property p_boost;
		duty_reg[5] |=> ctrl.duty_span_pct == 3'h5 && ctrl.duty_range_boost;
	endproperty
	a_boost: assert property (p_boost) else $error("boost span not applied");

	property p_rate;
		(wr_commit && addr == `DCT_ADDR_PLLREF) |=> ##1 ctrl.ref_rate == $past(wr_data[5:4], 2);
	endproperty
	a_rate: assert property (p_rate) else $error("reference rate not applied");

	property p_reserved;
		(sclk_rise && bit_cnt == 5'h0f && {shift_in[13:0], sdi_f} == `DCT_ADDR_PD) |=> rd_shift[7:1] == 7'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	sequence s_crs_write;
		wr_commit && addr == `DCT_ADDR_CRS;
	endsequence

	property p_crs_write;
		s_crs_write |=> crs_en_reg == $past(wr_data[`DCT_CRS_EN]) && crs_adj_reg == $past(wr_data[3:0]);
	endproperty
	a_crs_write: assert property (p_crs_write) else $error("crossing write not stored");

	property p_pd_hold;
		!(wr_commit && addr == `DCT_ADDR_PD) |=> $stable(pd_reg);
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("power-down changed without a write");
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic               ref_clk;
	logic               rst;
	logic               spi_cs_n;
	logic               spi_sclk;
	logic               spi_sdi;
	logic               spi_sdo;
	logic               spi_sdo_oe;
	dct_pkg::dct_ctrl_t ctrl;
	int                 miscompares;
	int                 checks_done;
	logic [7:0]         rd_byte;
	logic [7:0]         oe_byte;
	logic [5:0]         codes [5] = '{6'h00, 6'h1f, 6'h20, 6'h21, 6'h3f};
	logic [7:0]         duty [4] = '{8'h3f, 8'h0a, 8'hd0, 8'h9f};

	dct_clock_regs i_dut (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.spi_cs_n   (spi_cs_n),
		.spi_sclk   (spi_sclk),
		.spi_sdi    (spi_sdi),
		.spi_sdo    (spi_sdo),
		.spi_sdo_oe (spi_sdo_oe),
		.ctrl       (ctrl)
	);

	always #2 ref_clk = ~ref_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (miscompares == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// fewer than 24 bits aborts the frame; phases of 8 cycles leave margin for the pin sync
	task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] wdata, input int nbits);
		logic [23:0] word;
		word = {rd, addr, wdata};
		rd_byte = 8'h00;
		oe_byte = 8'h00;
		tick(1);
		spi_cs_n <= 1'b0;
		tick(8);
		for (int i = 0; i < nbits; i++) begin
			spi_sdi <= word[23 - i];
			tick(8);
			if (i >= 16) begin
				rd_byte = {rd_byte[6:0], spi_sdo};
				oe_byte = {oe_byte[6:0], spi_sdo_oe};
			end
			spi_sclk <= 1'b1;
			tick(8);
			spi_sclk <= 1'b0;
		end
		tick(8);
		spi_cs_n <= 1'b1;
		tick(12);
	endtask

	task automatic wr(input logic [14:0] addr, input logic [7:0] data);
		frame(1'b0, addr, data, 24);
		check(oe_byte, 8'h00);
	endtask

	task automatic rdchk(input logic [14:0] addr, input logic [7:0] exp);
		frame(1'b1, addr, 8'h00, 24);
		check(rd_byte, exp);
		check(oe_byte, 8'hff);
		check(spi_sdo_oe, 1'b0);
	endtask

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
		miscompares = 0;
		checks_done = 0;
		tick(20);
		rst <= 1'b0;
		tick(8);
		check(ctrl.powerdown, 1'b1);
		check(ctrl.ref_rate, 2'h0);
		check(ctrl.duty_span_pct, 3'h3);
		rdchk(15'h0080, 8'h01);
		rdchk(15'h0082, 8'h80);
		rdchk(15'h0083, 8'h80);
		rdchk(15'h0084, 8'h00);
		rdchk(15'h007f, 8'h00);
		wr(15'h0080, 8'hff);
		rdchk(15'h0080, 8'h01);
		wr(15'h0080, 8'hfe);
		rdchk(15'h0080, 8'h00);
		check(ctrl.powerdown, 1'b0);
		// cut short before the last data bit, so nothing may land
		frame(1'b0, 15'h0080, 8'h01, 20);
		check(ctrl.powerdown, 1'b0);
		foreach (codes[k]) begin
			wr(15'h007f, {2'b11, codes[k]});
			rdchk(15'h007f, {2'b00, codes[k]});
			check(ctrl.pos_cap, codes[k][5] ? 5'h00 : codes[k][4:0]);
			check(ctrl.neg_cap, codes[k][5] ? codes[k][4:0] : 5'h00);
		end
		foreach (duty[k]) begin
			wr(15'h0082, duty[k]);
			rdchk(15'h0082, duty[k]);
			check(ctrl.duty_dir, duty[k][4]);
			check(ctrl.duty_mag, duty[k][3:0]);
			check(ctrl.duty_span_pct, duty[k][5] ? 3'h5 : 3'h3);
			check({ctrl.duty_enable, ctrl.duty_offset_en, ctrl.duty_range_boost}, duty[k][7:5]);
		end
		wr(15'h0083, 8'hff);
		rdchk(15'h0083, 8'h8f);
		check({ctrl.crossing_adjust_enable, ctrl.crossing_point_trim}, 5'h1f);
		wr(15'h0083, 8'h70);
		rdchk(15'h0083, 8'h00);
		wr(15'h0084, 8'hdf);
		rdchk(15'h0084, 8'h10);
		check(ctrl.ref_rate, 2'h1);
		wr(15'h0084, 8'hcf);
		rdchk(15'h0084, 8'h00);
		check(ctrl.ref_rate, 2'h0);
		wr(15'h0081, 8'hff);
		rdchk(15'h0081, 8'h00);
		rdchk(15'h0080, 8'h00);
		complete_run();
	end

	// tests need about 16k cycles; this allows roughly three times that
	initial begin
		#200us;
		miscompares++;
		complete_run();
	end
endmodule
